// ### design/spmp_port.sv
// Byte-wide serial peripheral port, master or slave, behind an APB slave.
// Assumes pins already synchronous to clock; CPU halt and interrupt mask as inputs.
//
// Design decisions made here: the APB slave port and the address map.

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Write during transfer is discarded, transfer continues
// - Collision flag set in master and slave
// - Collision flag never requests an interrupt
// - Received byte buffered, read never collides
// - Wait state: port runs, events wake
// - Halt freezes port and registers, except an enabled slave armed for wake
// - Slave completion wakes CPU from halt
// - Second byte before flag clear sets overrun
// - Halt wake only if select low at entry
// - Leaving slave mode restores normal state
// - Three events share one gated request
// - Interrupt enable bit gates the request
// - Port enable owns pins, cleared by fault
// - Master bit sets directions, cleared by fault
// - Idle level bit sets clock idle state
// - Phase bit picks first capture edge
// - Master clock divided by six rate codes
// - Rate bits ignored in slave mode
// - Unwritten slave echoes previously received byte
module spmp_port
	import spmp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_halt,
	input wire logic cpu_int_mask,
	output logic irq_o,
	output logic halt_wake_o,
	output logic pins_owned_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n,
	input wire logic ss_n_i
);
	logic [7:0] ctrl_r;
	logic sod_r, ssm_r, ssi_r;
	logic tc_r, write_collision_flag_r, ovr_r, mode_fault_flag_r;
	logic tc_arm_r, write_collision_flag_arm_r, mode_fault_flag_arm_r;
	logic [7:0] rx_r, sr_r, sr_nxt;
	logic out_r, run_r, sck_r, sck_prev_r;
	logic [4:0] cnt_r, n;
	logic [5:0] div_r, half;
	logic halt_prev_r, wake_ok_r;
	logic irq_r, wake_r, pins_r;
	logic sck_oe_n_r, mosi_oe_n_r, miso_oe_n_r;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic en, master_select_bit, capture_edge_select, ss_eff, freeze, acc, acc_dr, wr_dr, acc_csr, rd_csr;
	logic wr_csr, wr_ctrl, busy, div_tick, slv_edge, edge_ev, capt, done;
	logic dr_ok, collide, fault, din, mapped;

	assign en = ctrl_r[CTRL_EN];
	assign master_select_bit = ctrl_r[CTRL_MASTER_SELECT_BIT];
	assign capture_edge_select = ctrl_r[CTRL_CAPTURE_EDGE_SELECT];
	assign ss_eff = ssm_r ? ssi_r : ss_n_i;
	// Slave may keep shifting in halt when wake was armed at entry
	assign freeze = cpu_halt & ~(wake_ok_r & ~master_select_bit & en);
	assign acc = psel & penable & pready_r;
	assign acc_dr = acc & (paddr == ADDR_DATA) & ~freeze;
	assign wr_dr = acc_dr & pwrite;
	assign acc_csr = acc & (paddr == ADDR_CSR) & ~freeze;
	assign rd_csr = acc_csr & ~pwrite;
	assign wr_csr = acc_csr & pwrite;
	assign wr_ctrl = acc & (paddr == ADDR_CTRL) & pwrite & ~freeze;
	assign mapped = (paddr == ADDR_DATA) | (paddr == ADDR_CSR) | (paddr == ADDR_CTRL);
	assign busy = run_r | (cnt_r != 5'h00);
	assign half = spmp_half({ctrl_r[CTRL_DIVEN], ctrl_r[CTRL_RATE_HI], ctrl_r[CTRL_RATE_LO]});
	assign div_tick = run_r & (div_r == half) & ~freeze;
	assign slv_edge = en & ~master_select_bit & ~ss_eff & (sck_i != sck_prev_r) & ~freeze;
	assign edge_ev = div_tick | slv_edge;
	assign n = cnt_r + 5'h01;
	assign capt = n[0] ^ capture_edge_select;
	assign din = master_select_bit ? miso_i : mosi_i;
	assign sr_nxt = (edge_ev & capt) ? {sr_r[6:0], din} : sr_r;
	assign done = edge_ev & (n == EDGES_PER_BYTE);
	assign collide = wr_dr & busy;
	assign dr_ok = wr_dr & ~busy & ~(tc_r & ~tc_arm_r);
	assign fault = en & master_select_bit & ~ss_eff & ~freeze;

	////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (psel & penable & ~pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= ~mapped;
			case (paddr)
				ADDR_DATA: prdata_r <= {24'h000000, rx_r};
				ADDR_CSR: prdata_r <= {24'h000000, tc_r, write_collision_flag_r, ovr_r, mode_fault_flag_r,
					1'b0, sod_r, ssm_r, ssi_r};
				ADDR_CTRL: prdata_r <= {24'h000000, ctrl_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and software select bits
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_r <= CTRL_RESET;
		end else if (fault) begin
			ctrl_r[CTRL_EN] <= 1'b0;
			ctrl_r[CTRL_MASTER_SELECT_BIT] <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata[7:0];
			if (mode_fault_flag_r & ~mode_fault_flag_arm_r) begin
				ctrl_r[CTRL_EN] <= ctrl_r[CTRL_EN];
				ctrl_r[CTRL_MASTER_SELECT_BIT] <= ctrl_r[CTRL_MASTER_SELECT_BIT];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sod_r <= 1'b0;
			ssm_r <= 1'b0;
			ssi_r <= 1'b0;
		end else if (wr_csr) begin
			sod_r <= pwdata[CSR_SOD];
			ssm_r <= pwdata[CSR_SSM];
			ssi_r <= pwdata[CSR_SSI];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift engine
	always_ff @(posedge clock) begin
		if (rst) begin
			sr_r <= 8'h00;
			out_r <= 1'b0;
			cnt_r <= 5'h00;
			run_r <= 1'b0;
		end else if (!freeze) begin
			if (dr_ok) begin
				sr_r <= pwdata[7:0];
				out_r <= pwdata[7];
				cnt_r <= 5'h00;
				run_r <= master_select_bit & en;
			end else begin
				// Received byte stays in the shifter for echo
				sr_r <= sr_nxt;
				if (edge_ev & ~capt)
					out_r <= sr_r[7];
				if (done) begin
					cnt_r <= 5'h00;
					run_r <= 1'b0;
				end else if (edge_ev) begin
					cnt_r <= n;
				end
				if (~en) begin
					run_r <= 1'b0;
					cnt_r <= 5'h00;
				end else if (~master_select_bit & ss_eff) begin
					cnt_r <= 5'h00;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			div_r <= 6'h00;
		else if (!freeze) begin
			if (~run_r | (div_r == half))
				div_r <= 6'h00;
			else
				div_r <= div_r + 6'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sck_r <= 1'b0;
			sck_prev_r <= 1'b0;
		end else begin
			sck_prev_r <= sck_i;
			if (~run_r)
				sck_r <= ctrl_r[CTRL_CLOCK_IDLE_LEVEL];
			else if (div_tick)
				sck_r <= ~sck_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags; a set always wins over a clear
	always_ff @(posedge clock) begin
		if (rst) begin
			tc_r <= 1'b0;
			tc_arm_r <= 1'b0;
			ovr_r <= 1'b0;
			rx_r <= 8'h00;
		end else begin
			tc_r <= done | (tc_r & ~(tc_arm_r & acc_dr));
			tc_arm_r <= tc_r & ~(tc_arm_r & acc_dr) & (tc_arm_r | acc_csr);
			ovr_r <= (done & tc_r) | (ovr_r & ~rd_csr);
			if (done & ~tc_r)
				rx_r <= sr_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			write_collision_flag_r <= 1'b0;
			write_collision_flag_arm_r <= 1'b0;
			mode_fault_flag_r <= 1'b0;
			mode_fault_flag_arm_r <= 1'b0;
		end else begin
			write_collision_flag_r <= collide | (write_collision_flag_r & ~(write_collision_flag_arm_r & acc_dr));
			write_collision_flag_arm_r <= write_collision_flag_r & ~(write_collision_flag_arm_r & acc_dr) & (write_collision_flag_arm_r | rd_csr);
			mode_fault_flag_r <= fault | (mode_fault_flag_r & ~(mode_fault_flag_arm_r & wr_ctrl));
			mode_fault_flag_arm_r <= mode_fault_flag_r & ~(mode_fault_flag_arm_r & wr_ctrl) & (mode_fault_flag_arm_r | rd_csr);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request and halt wake
	always_ff @(posedge clock) begin
		if (rst) begin
			halt_prev_r <= 1'b0;
			wake_ok_r <= 1'b0;
		end else begin
			halt_prev_r <= cpu_halt;
			if (~cpu_halt)
				wake_ok_r <= 1'b0;
			else if (~halt_prev_r)
				wake_ok_r <= ~ss_eff;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			// Request also ends CPU wait
			irq_r <= ctrl_r[CTRL_IE] & ~cpu_int_mask & (tc_r | mode_fault_flag_r | ovr_r);
			wake_r <= cpu_halt & wake_ok_r & ctrl_r[CTRL_IE] & ~cpu_int_mask & tc_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers
	always_ff @(posedge clock) begin
		if (rst) begin
			pins_r <= 1'b0;
			sck_oe_n_r <= 1'b1;
			mosi_oe_n_r <= 1'b1;
			miso_oe_n_r <= 1'b1;
		end else begin
			pins_r <= en;
			sck_oe_n_r <= ~(en & master_select_bit);
			mosi_oe_n_r <= ~(en & master_select_bit & ~sod_r);
			miso_oe_n_r <= ~(en & ~master_select_bit & ~sod_r & ~ss_eff);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq_o = irq_r;
	assign halt_wake_o = wake_r;
	assign pins_owned_o = pins_r;
	assign sck_o = sck_r;
	assign sck_oe_n = sck_oe_n_r;
	assign mosi_o = out_r;
	assign mosi_oe_n = mosi_oe_n_r;
	assign miso_o = out_r;
	assign miso_oe_n = miso_oe_n_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_collision_flag: assert property (@(posedge clock) disable iff (rst)
		collide |=> write_collision_flag_r) else $error("collision not flagged");
	chk_collision_drop: assert property (@(posedge clock) disable iff (rst)
		collide && !edge_ev |=> $stable(sr_r) && $stable(cnt_r))
		else $error("colliding write disturbed shifter");
	chk_irq_source: assert property (@(posedge clock) disable iff (rst)
		irq_o |-> $past(tc_r | mode_fault_flag_r | ovr_r)) else $error("request without event");
	chk_irq_gate: assert property (@(posedge clock) disable iff (rst)
		$past(ctrl_r[CTRL_IE] & ~cpu_int_mask & tc_r) |-> irq_o)
		else $error("enabled completion gave no request");
	chk_overrun_keep: assert property (@(posedge clock) disable iff (rst)
		done && tc_r |=> ovr_r && $stable(rx_r)) else $error("overrun mishandled");
	chk_rx_load: assert property (@(posedge clock) disable iff (rst)
		done && !tc_r |=> tc_r && rx_r == $past(sr_nxt)) else $error("buffer not loaded");
	chk_mode_fault: assert property (@(posedge clock) disable iff (rst)
		fault |=> !ctrl_r[CTRL_EN] && !ctrl_r[CTRL_MASTER_SELECT_BIT] && mode_fault_flag_r)
		else $error("mode fault not taken");
	chk_halt_frozen: assert property (@(posedge clock) disable iff (rst)
		freeze |=> $stable(ctrl_r) && $stable(sr_r) && $stable(tc_r))
		else $error("state moved in halt");
	chk_idle_level: assert property (@(posedge clock) disable iff (rst)
		!run_r && !$past(run_r) |-> sck_o == $past(ctrl_r[CTRL_CLOCK_IDLE_LEVEL]))
		else $error("clock not at idle level");
	chk_sck_rate: assert property (@(posedge clock) disable iff (rst)
		run_r && $changed(sck_o) |-> $past(div_r) == $past(half))
		else $error("clock toggled off rate");
	chk_halt_wake: assert property (@(posedge clock) disable iff (rst)
		halt_wake_o |-> $past(wake_ok_r)) else $error("wake without armed select");
	chk_write_collision_flag_quiet: assert property (@(posedge clock) disable iff (rst)
		write_collision_flag_r && !tc_r && !mode_fault_flag_r && !ovr_r |=> !irq_o)
		else $error("collision flag raised a request");
	chk_busy_end: assert property (@(posedge clock) disable iff (rst)
		done |=> !busy)
		else $error("busy after completion");
	chk_write_inhibit: assert property (@(posedge clock) disable iff (rst)
		wr_dr && tc_r && !tc_arm_r && !edge_ev |=> $stable(sr_r))
		else $error("write accepted while completion pending");
	chk_slave_norate: assert property (@(posedge clock) disable iff (rst)
		!master_select_bit && !$past(master_select_bit) |-> !div_tick)
		else $error("divider ticked in slave mode");
	chk_wake_source: assert property (@(posedge clock) disable iff (rst)
		halt_wake_o |-> $past(tc_r) && $past(cpu_halt))
		else $error("wake without completion in halt");
	chk_wake_tc_only: assert property (@(posedge clock) disable iff (rst)
		!tc_r |=> !halt_wake_o)
		else $error("wake from event other than completion");
	chk_irq_masked: assert property (@(posedge clock) disable iff (rst)
		cpu_int_mask || !ctrl_r[CTRL_IE] |=> !irq_o)
		else $error("request while inhibited");
	chk_pins_released: assert property (@(posedge clock) disable iff (rst)
		!ctrl_r[CTRL_EN] |=> !pins_owned_o && sck_oe_n && mosi_oe_n && miso_oe_n)
		else $error("pins held while disabled");
	chk_master_dirs: assert property (@(posedge clock) disable iff (rst)
		ctrl_r[CTRL_EN] && ctrl_r[CTRL_MASTER_SELECT_BIT] |=> !sck_oe_n && miso_oe_n)
		else $error("master pin directions wrong");
	chk_rx_hold: assert property (@(posedge clock) disable iff (rst)
		!done |=> $stable(rx_r))
		else $error("receive buffer moved without completion");
	chk_select_clear: assert property (@(posedge clock) disable iff (rst)
		en && !master_select_bit && ss_eff && !freeze && !dr_ok |=> cnt_r == 5'h00)
		else $error("deselected slave kept its count");
	chk_halt_arm: assert property (@(posedge clock) disable iff (rst)
		cpu_halt && !halt_prev_r |=> wake_ok_r == !$past(ss_eff))
		else $error("wake arming wrong at halt entry");
	chk_wait_runs: assert property (@(posedge clock) disable iff (rst)
		!cpu_halt && div_tick |=> $changed(sck_o))
		else $error("clock stalled outside halt");
	chk_capture_phase: assert property (@(posedge clock) disable iff (rst)
		edge_ev && !dr_ok && (cnt_r[0] == capture_edge_select) |=> sr_r == {$past(sr_r[6:0]), $past(din)})
		else $error("bit not captured on phase edge");
	chk_collide_master: assert property (@(posedge clock) disable iff (rst)
		wr_dr && run_r |=> write_collision_flag_r)
		else $error("master collision not flagged");
endmodule

// ### design/spmp_pkg.sv
// Constants shared by the byte-wide serial port: register map, fields, rates.
// Assumes a 32-bit APB slave with one aligned word per register.
package spmp_pkg;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_CSR = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	// Control register fields
	localparam int CTRL_IE = 7;
	localparam int CTRL_EN = 6;
	localparam int CTRL_DIVEN = 5;
	localparam int CTRL_MASTER_SELECT_BIT = 4;
	localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
	localparam int CTRL_CAPTURE_EDGE_SELECT = 2;
	localparam int CTRL_RATE_HI = 1;
	localparam int CTRL_RATE_LO = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Control/status register fields
	localparam int CSR_TC = 7;
	localparam int CSR_WRITE_COLLISION_FLAG = 6;
	localparam int CSR_OVR = 5;
	localparam int CSR_MODE_FAULT_FLAG = 4;
	localparam int CSR_SOD = 2;
	localparam int CSR_SSM = 1;
	localparam int CSR_SSI = 0;
	// Clock edges per byte (two per bit)
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	// Half-period count minus one for each rate code {diven, rate}
	function automatic logic [5:0] spmp_half(input logic [2:0] code);
		case (code)
			3'h4: spmp_half = 6'h01;
			3'h0: spmp_half = 6'h03;
			3'h1: spmp_half = 6'h07;
			3'h6: spmp_half = 6'h0F;
			3'h2: spmp_half = 6'h1F;
			3'h3: spmp_half = 6'h3F;
			default: spmp_half = 6'h03;
		endcase
	endfunction
endpackage

// ### sim/spmp_partner.sv
// External serial slave that echoes each received byte on the next transfer.
// Assumes sck and mosi are sampled on the port clock; idle and phase come from the bench.
module spmp_partner (
	input wire logic clock,
	input wire logic sel_n,
	input wire logic clock_idle_level,
	input wire logic capture_edge_select,
	input wire logic sck,
	input wire logic mosi,
	output logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck_q = 1'b0;
	logic last = 1'b0;
	logic [7:0] rx = 8'h00;
	logic [7:0] tx = 8'h00;
	logic [2:0] n = 3'h0;
	// Released line shows the inverse of its last level
	assign miso = sel_n ? !last : tx[3'h7 - n];
	always @(posedge clock) begin
		sck_q <= sck;
		if (!sel_n) begin
			last <= miso;
		end
		if (!sel_n && sck != sck_q && ((sck != clock_idle_level) ^ capture_edge_select)) begin
			rx <= {rx[6:0], mosi};
			n <= n + 3'h1;
			if (n == 3'h7) begin
				tx <= {rx[6:0], mosi};
			end
		end
	end
endmodule

// ### sim/tb_top.sv
// Bench for the serial port in master mode against an echoing slave, then in slave mode.
// Assumes one clock and APB register access; CPU halt is driven only in the slave-mode tests.
module tb_top import spmp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, irq_o, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
	logic mask = 1'b0;
	logic ss_n = 1'b1;
	logic sel_n = 1'b1;
	logic clock_idle_level = 1'b0;
	logic capture_edge_select = 1'b0;
	logic arm = 1'b0;
	logic sck_q = 1'b0;
	logic ext_sck = 1'b0;
	logic ext_mosi = 1'b1;
	logic halt = 1'b0;
	logic wake;
	logic [7:0] s_ctl, got, sb;
	logic p_miso, owned;
	logic [7:0] prev = 8'h00;
	logic [7:0] ctl;
	logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int gap = 0;
	int tog = 0;
	int half = 0;
	wire sck_w = sck_oe_n ? ext_sck : sck_o;
	wire mosi_w = mosi_oe_n ? ext_mosi : mosi_o;
	wire miso_w = miso_oe_n ? p_miso : miso_o;
	spmp_port u_spmp_port (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_halt(halt), .cpu_int_mask(mask), .irq_o(irq_o),
		.halt_wake_o(wake), .pins_owned_o(owned), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n));
	spmp_partner u_spmp_partner (.clock(clock), .sel_n(sel_n), .clock_idle_level(clock_idle_level), .capture_edge_select(capture_edge_select),
		.sck(sck_w), .mosi(mosi_w), .miso(p_miso));
	initial begin
		forever #12.5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic int fac_half(input logic [2:0] c);
		case (c)
			3'h4: return 2;
			3'h0: return 4;
			3'h1: return 8;
			3'h6: return 16;
			3'h2: return 32;
			default: return 64;
		endcase
	endfunction
	task xfer(input logic [7:0] b, input logic coll);
		sel_n <= 1'b0;
		tog = 0;
		arm = 1'b1;
		apb(1'b1, ADDR_DATA, {24'h0, b});
		if (coll) begin
			repeat (3 * half) @(posedge clock);
			apb(1'b1, ADDR_DATA, {24'h0, ~b});
		end
		for (int k = 0; k < 3000 && tog < 16; k++) @(posedge clock);
		repeat (4) @(posedge clock);
		chk(tog, EDGES_PER_BYTE, "edge count");
		chk(irq_o, !mask, "masked request");
		mask <= 1'b0;
		repeat (3) @(posedge clock);
		chk(irq_o, 1'b1, "completion request");
		arm = 1'b0;
		sel_n <= 1'b1;
		apb(1'b0, ADDR_CSR, 32'h0);
		chk(rd[7:4], {1'b1, coll, 2'h0}, "status");
		apb(1'b0, ADDR_DATA, 32'h0);
		chk(rd, {24'h0, prev}, "echo byte");
		prev = b;
		repeat (3) @(posedge clock);
		chk(irq_o, 1'b0, "request after clear");
	endtask
	// Bench acts as external master, one byte, idle level from clock_idle_level
	task sxfer(input logic [7:0] b, input logic coll, output logic [7:0] g);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		for (int k = 0; k < 8; k++) begin
			ext_mosi <= b[7 - k];
			repeat (4) @(posedge clock);
			g = {g[6:0], miso_w};
			ext_sck <= ~clock_idle_level;
			if (coll && k == 3) begin
				apb(1'b1, ADDR_DATA, {24'h0, ~b});
			end else begin
				repeat (4) @(posedge clock);
			end
			ext_sck <= clock_idle_level;
		end
		repeat (4) @(posedge clock);
		ss_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	task sread(input logic [3:0] st, input logic [7:0] d);
		apb(1'b0, ADDR_CSR, 32'h0);
		chk(rd[7:4], st, "slave status");
		apb(1'b0, ADDR_DATA, 32'h0);
		chk(rd, {24'h0, d}, "slave byte");
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		gap <= gap + 1;
		sck_q <= sck_o;
		if (arm && sck_o !== sck_q) begin
			gap <= 1;
			tog <= tog + 1;
			if (tog > 0) begin
				chk(gap, half, "sck half period");
			end
		end
		if (cyc == 60000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(59568));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {24'h0, CTRL_RESET}, "control reset");
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1'b1, "unmapped error");
		for (int i = 0; i < 6; i++) begin
			half = fac_half(codes[i]);
			ctl = {1'b1, 1'b0, codes[i][2], 1'b1, 1'($urandom), 1'($urandom), codes[i][1:0]};
			apb(1'b1, ADDR_CTRL, {24'h0, ctl});
			clock_idle_level <= ctl[CTRL_CLOCK_IDLE_LEVEL];
			capture_edge_select <= ctl[CTRL_CAPTURE_EDGE_SELECT];
			ext_sck <= ctl[CTRL_CLOCK_IDLE_LEVEL];
			ctl[CTRL_EN] = 1'b1;
			apb(1'b1, ADDR_CTRL, {24'h0, ctl});
			repeat (2) @(posedge clock);
			chk(sck_o, ctl[CTRL_CLOCK_IDLE_LEVEL], "idle level");
			chk({owned, sck_oe_n}, 2'h2, "pins owned");
			mask <= (i == 2);
			xfer(8'($urandom), i == 1);
		end
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk(owned, 1'b0, "fault releases pins");
		chk(irq_o, 1'b1, "fault request");
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk({rd[CTRL_EN], rd[CTRL_MASTER_SELECT_BIT]}, 2'h0, "fault clears bits");
		apb(1'b0, ADDR_CSR, 32'h0);
		chk(rd[CSR_MODE_FAULT_FLAG], 1'b1, "fault flag");
		ss_n <= 1'b1;
		s_ctl = {1'b1, 1'b1, 1'($urandom), 1'b0, 1'($urandom), 1'b0, 2'($urandom)};
		clock_idle_level <= s_ctl[CTRL_CLOCK_IDLE_LEVEL];
		ext_sck <= s_ctl[CTRL_CLOCK_IDLE_LEVEL];
		apb(1'b1, ADDR_CTRL, {24'h0, s_ctl});
		sb = 8'($urandom);
		apb(1'b1, ADDR_DATA, {24'h0, sb});
		ctl = 8'($urandom);
		sxfer(ctl, 1'b0, got);
		chk(got, sb, "slave sends loaded byte");
		sread(4'h8, ctl);
		sxfer(~ctl, 1'b1, got);
		chk(got, ctl, "slave echo");
		sread(4'hC, ~ctl);
		// Select high at halt entry: port frozen
		halt <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h0);
		halt <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {24'h0, s_ctl}, "halt froze control");
		// Select low at halt entry: completion wakes
		ss_n <= 1'b0;
		repeat (2) @(posedge clock);
		halt <= 1'b1;
		sb = ~ctl;
		ctl = 8'($urandom);
		sxfer(ctl, 1'b0, got);
		chk(got, sb, "echo during halt");
		chk(wake, 1'b1, "halt wake");
		halt <= 1'b0;
		sread(4'h8, ctl);
		sxfer(sb, 1'b0, got);
		chk(got, ctl, "extra cycle echo");
		sread(4'h8, sb);
		stop_test();
	end
endmodule
